// *** src/pchr_pkg.sv ***
package pchr_pkg;
   // Clock of the bank (PCI clock domain)
   localparam int CLK_PERIOD_NS = 4;

   // Configuration offsets (byte addresses, dword aligned)
   localparam logic [7:0] OFS_MEM_BASE = 8'h10;
   localparam logic [7:0] OFS_SUBSYS_ID = 8'h2C;
   localparam logic [7:0] OFS_CAP_PTR = 8'h34;
   localparam logic [7:0] OFS_INT_LAT = 8'h3C;

   // Memory base register
   localparam logic [31:0] MEM_BASE_RESET = 32'h00000000;
   localparam logic [31:0] MEM_BASE_WMASK = 32'hFFFFF800;
   localparam int MEM_BASE_LSB = 11;

   // Capabilities pointer
   localparam logic [7:0] CAP_PTR_PM = 8'h50;
   localparam logic [7:0] CAP_PTR_NONE = 8'h00;
   localparam int EE_NEW_CAP_BIT = 15;

   // Interrupt and latency fields
   localparam logic [7:0] MAX_LAT_VALUE = 8'h28;
   localparam logic [7:0] MIN_GNT_VALUE = 8'h14;
   localparam logic [7:0] INT_PIN_VALUE = 8'h01;
   localparam logic [7:0] INT_LINE_RESET = 8'h00;

   // EEPROM load sequencing
   localparam logic [15:0] LOAD_START_CYCLES = 16'h0032;
   localparam logic [15:0] LOAD_MIN_DEFAULT = 16'h6B08;
   localparam logic [15:0] LOAD_CNT_MAX = 16'hFFFF;
   localparam logic [5:0] EE_ADDR_CONFIG = 6'h00;
   localparam logic [5:0] EE_ADDR_VENDOR = 6'h01;
   localparam logic [5:0] EE_ADDR_SUBSYS = 6'h02;

   // Serial EEPROM timing and framing
   localparam int EE_SK_PERIOD_NS = 2000;
   localparam int EE_HALF_CYCLES_INT = EE_SK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam logic [7:0] EE_HALF_CYCLES = 8'(EE_HALF_CYCLES_INT);
   localparam logic [2:0] EE_READ_OP = 3'h6;
   localparam logic [4:0] EE_CMD_LAST = 5'h08;
   localparam logic [4:0] EE_DATA_LAST = 5'h10;

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
      logic [3:0] byteEn;
      logic [31:0] wdata;
   } pchr_cfg_req_type;

   typedef struct packed {
      logic valid;
      logic retry;
      logic [31:0] rdata;
   } pchr_cfg_rsp_type;

   typedef struct packed {
      logic cs;
      logic sk;
      logic dout;
   } pchr_ee_pins_type;
endpackage : pchr_pkg

// *** src/pchr_ee_reader.sv ***
`timescale 1ns/1ps
module pchr_ee_reader (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Word request
   input wire logic start,
   input wire logic [5:0] wordAddr,
   output logic busy,
   output logic done,
   output logic [15:0] word,
   // Serial EEPROM pins
   output pchr_pkg::pchr_ee_pins_type eePins,
   input wire logic eeDataIn
);
   typedef enum logic [1:0] {EE_IDLE, EE_CMD, EE_DATA, EE_END} pchr_ee_state_type;

   pchr_ee_state_type state;
   logic [7:0] divCnt;
   logic [4:0] bitCnt;
   logic [8:0] cmdShift;
   logic sk;
   logic sync1;
   logic sync2;
   logic sync3;
   logic diLevel;

   wire tick = (divCnt == pchr_pkg::EE_HALF_CYCLES - 8'h01);
   wire fallEdge = tick & sk;
   wire active = (state == EE_CMD) | (state == EE_DATA);

   assign busy = (state != EE_IDLE);
   assign eePins.cs = active;
   assign eePins.sk = sk;
   assign eePins.dout = (state == EE_CMD) & cmdShift[8];

   // Input filter: level follows once the two later stages agree
   always_ff @(posedge clk) begin
      sync1 <= eeDataIn;
      sync2 <= sync1;
      sync3 <= sync2;
      if (srst) begin
         diLevel <= 1'b0;
      end else if (sync2 == sync3) begin
         diLevel <= sync3;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || !active || tick) begin
         divCnt <= 8'h00;
      end else begin
         divCnt <= divCnt + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || !active) begin
         sk <= 1'b0;
      end else if (tick) begin
         sk <= ~sk;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state <= EE_IDLE;
         bitCnt <= 5'h00;
         cmdShift <= 9'h000;
         word <= 16'h0000;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state)
            EE_IDLE: begin
               if (start) begin
                  cmdShift <= {pchr_pkg::EE_READ_OP, wordAddr};
                  bitCnt <= pchr_pkg::EE_CMD_LAST;
                  state <= EE_CMD;
               end
            end
            EE_CMD: begin
               if (fallEdge) begin
                  cmdShift <= {cmdShift[7:0], 1'b0};
                  bitCnt <= bitCnt - 5'h01;
                  if (bitCnt == 5'h00) begin
                     bitCnt <= pchr_pkg::EE_DATA_LAST;
                     state <= EE_DATA;
                  end
               end
            end
            EE_DATA: begin
               // Dummy zero shifts out of the top, data lands MSB first
               if (fallEdge) begin
                  word <= {word[14:0], diLevel};
                  bitCnt <= bitCnt - 5'h01;
                  if (bitCnt == 5'h00) begin
                     state <= EE_END;
                  end
               end
            end
            EE_END: begin
               done <= 1'b1;
               state <= EE_IDLE;
            end
            default: begin
               state <= EE_IDLE;
            end
         endcase
      end
   end
endmodule : pchr_ee_reader

// *** src/pchr_regs.sv ***
`timescale 1ns/1ps
module pchr_regs #(
   parameter logic [15:0] LOAD_MIN_CYCLES = pchr_pkg::LOAD_MIN_DEFAULT
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Configuration access
   input pchr_pkg::pchr_cfg_req_type cfgReq,
   output pchr_pkg::pchr_cfg_rsp_type cfgRsp,
   // CSR memory decode
   input wire logic [31:0] memAddr,
   output logic memHit,
   // Status towards the rest of the header
   output logic newCapEnabled,
   output logic subsysLoaded,
   output logic [7:0] interruptLine,
   // Serial EEPROM
   output pchr_pkg::pchr_ee_pins_type eePins,
   input wire logic eeDataIn
);
   typedef enum logic [2:0] {LD_WAIT, LD_CONFIG, LD_VENDOR, LD_SUBSYS, LD_HOLD, LD_DONE} pchr_load_state_type;

   pchr_load_state_type loadState;
   logic [15:0] loadCnt;
   logic [31:0] memBase;
   logic [7:0] intLine;
   logic [15:0] eeConfig;
   logic [15:0] subsysVendor;
   logic [15:0] subsysId;
   logic rspValid;
   logic rspRetry;
   logic [31:0] rspData;
   logic readerBusy;
   logic readerDone;
   logic [15:0] readerWord;

   // Load sequencing
   wire startHit = (loadState == LD_WAIT) & (loadCnt == pchr_pkg::LOAD_START_CYCLES - 16'h0001);
   wire [15:0] loadEnd = pchr_pkg::LOAD_START_CYCLES + LOAD_MIN_CYCLES;
   wire minElapsed = (loadCnt >= loadEnd);
   wire nextRead = readerDone & ((loadState == LD_CONFIG) | (loadState == LD_VENDOR));
   wire readerStart = startHit | nextRead;
   wire [5:0] readerAddr = (loadState == LD_WAIT) ? pchr_pkg::EE_ADDR_CONFIG :
                           (loadState == LD_CONFIG) ? pchr_pkg::EE_ADDR_VENDOR :
                           pchr_pkg::EE_ADDR_SUBSYS;

   // Address decode
   wire [5:0] dwordIdx = cfgReq.addr[7:2];
   wire hitBase = (dwordIdx == pchr_pkg::OFS_MEM_BASE[7:2]);
   wire hitSubsys = (dwordIdx == pchr_pkg::OFS_SUBSYS_ID[7:2]);
   wire hitCap = (dwordIdx == pchr_pkg::OFS_CAP_PTR[7:2]);
   wire hitInt = (dwordIdx == pchr_pkg::OFS_INT_LAT[7:2]);
   wire wrBase = cfgReq.valid & cfgReq.write & hitBase;
   wire wrInt = cfgReq.valid & cfgReq.write & hitInt & cfgReq.byteEn[0];
   wire rdRetry = cfgReq.valid & ~cfgReq.write & hitSubsys & ~subsysLoaded;

   // Byte-lane write of the base, low bits never stored
   wire [31:0] laneMask;
   for (genvar lane = 0; lane < 4; lane++) begin : gLane
      assign laneMask[8 * lane +: 8] = {8{cfgReq.byteEn[lane]}};
   end
   wire [31:0] baseWrMask = laneMask & pchr_pkg::MEM_BASE_WMASK;
   wire [31:0] next_memBase = (memBase & ~baseWrMask) | (cfgReq.wdata & baseWrMask);

   // Read data per register
   wire [31:0] baseRead = memBase & pchr_pkg::MEM_BASE_WMASK;
   wire [31:0] subsysRead = {subsysId, subsysVendor};
   wire [7:0] capPtr = eeConfig[pchr_pkg::EE_NEW_CAP_BIT] ? pchr_pkg::CAP_PTR_PM : pchr_pkg::CAP_PTR_NONE;
   wire [31:0] capRead = {24'h000000, capPtr};
   wire [31:0] intRead = {pchr_pkg::MAX_LAT_VALUE, pchr_pkg::MIN_GNT_VALUE,
                          pchr_pkg::INT_PIN_VALUE, intLine};
   logic [31:0] readData;
   always_comb begin
      if (hitBase) begin
         readData = baseRead;
      end else if (hitSubsys) begin
         readData = subsysRead;
      end else if (hitCap) begin
         readData = capRead;
      end else if (hitInt) begin
         readData = intRead;
      end else begin
         readData = 32'h00000000;
      end
   end

   assign cfgRsp.valid = rspValid;
   assign cfgRsp.retry = rspRetry;
   assign cfgRsp.rdata = rspData;
   assign memHit = (memAddr[31:pchr_pkg::MEM_BASE_LSB] == memBase[31:pchr_pkg::MEM_BASE_LSB]);
   assign newCapEnabled = eeConfig[pchr_pkg::EE_NEW_CAP_BIT];
   assign subsysLoaded = (loadState == LD_DONE);
   assign interruptLine = intLine;

   pchr_ee_reader eeReader (
      .clk(clk),
      .srst(srst),
      .start(readerStart),
      .wordAddr(readerAddr),
      .busy(readerBusy),
      .done(readerDone),
      .word(readerWord),
      .eePins(eePins),
      .eeDataIn(eeDataIn)
   );

   // Cycle count since reset release, saturating
   always_ff @(posedge clk) begin
      if (srst) begin
         loadCnt <= 16'h0000;
      end else if (loadCnt != pchr_pkg::LOAD_CNT_MAX) begin
         loadCnt <= loadCnt + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         loadState <= LD_WAIT;
      end else begin
         case (loadState)
            LD_WAIT: begin
               if (startHit && !readerBusy) begin
                  loadState <= LD_CONFIG;
               end
            end
            LD_CONFIG: begin
               if (readerDone) begin
                  loadState <= LD_VENDOR;
               end
            end
            LD_VENDOR: begin
               if (readerDone) begin
                  loadState <= LD_SUBSYS;
               end
            end
            LD_SUBSYS: begin
               if (readerDone) begin
                  loadState <= LD_HOLD;
               end
            end
            LD_HOLD: begin
               if (minElapsed) begin
                  loadState <= LD_DONE;
               end
            end
            LD_DONE: begin
               loadState <= LD_DONE;
            end
            default: begin
               loadState <= LD_WAIT;
            end
         endcase
      end
   end

   // EEPROM words captured; no host path writes them
   always_ff @(posedge clk) begin
      if (srst) begin
         eeConfig <= 16'h0000;
         subsysVendor <= 16'h0000;
         subsysId <= 16'h0000;
      end else if (readerDone) begin
         if (loadState == LD_CONFIG) begin
            eeConfig <= readerWord;
         end
         if (loadState == LD_VENDOR) begin
            subsysVendor <= readerWord;
         end
         if (loadState == LD_SUBSYS) begin
            subsysId <= readerWord;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         memBase <= pchr_pkg::MEM_BASE_RESET;
         intLine <= pchr_pkg::INT_LINE_RESET;
      end else begin
         if (wrBase) begin
            memBase <= next_memBase;
         end
         if (wrInt) begin
            intLine <= cfgReq.wdata[7:0];
         end
      end
   end

   // One-cycle answer to every configuration request
   always_ff @(posedge clk) begin
      if (srst) begin
         rspValid <= 1'b0;
         rspRetry <= 1'b0;
         rspData <= 32'h00000000;
      end else begin
         rspValid <= cfgReq.valid;
         rspRetry <= rdRetry;
         if (cfgReq.valid && !cfgReq.write && !rdRetry) begin
            rspData <= readData;
         end else if (cfgReq.valid) begin
            rspData <= 32'h00000000;
         end
      end
   end
endmodule : pchr_regs

// *** sim/pchr_regs_properties.sv ***
`timescale 1ns/1ps
module pchr_regs_checker #(
   parameter logic [15:0] LOAD_MIN_CYCLES = pchr_pkg::LOAD_MIN_DEFAULT
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Watched ports
   input pchr_pkg::pchr_cfg_req_type cfgReq,
   input pchr_pkg::pchr_cfg_rsp_type cfgRsp,
   input wire logic newCapEnabled,
   input wire logic subsysLoaded,
   input wire logic [7:0] interruptLine,
   input pchr_pkg::pchr_ee_pins_type eePins
);
   logic [15:0] cnt;
   wire logic rd = cfgReq.valid && !cfgReq.write;
   wire logic [5:0] dw = cfgReq.addr[7:2];
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Cycles since reset release, saturating
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt <= 16'h0000;
      end else if (cnt != 16'hFFFF) begin
         cnt <= cnt + 16'h0001;
      end
   end
   sequence sidEarly;
      rd && dw == 6'h0B && !subsysLoaded;
   endsequence
   sequence retryOut;
      cfgRsp.valid && cfgRsp.retry && cfgRsp.rdata == 32'h00000000;
   endsequence
   rsp_follows_a: assert property (cfgReq.valid |=> cfgRsp.valid) else $error("response missing");
   rsp_spurious_a: assert property (!cfgReq.valid |=> !cfgRsp.valid) else $error("response unasked");
   sid_retry_a: assert property (sidEarly |=> retryOut) else $error("early read not retried");
   retry_only_a: assert property (cfgReq.valid && !(rd && dw == 6'h0B && !subsysLoaded) |=>
      !cfgRsp.retry) else $error("retry without cause");
   base_low_a: assert property (rd && dw == 6'h04 |=> cfgRsp.rdata[10:0] == 11'h000)
      else $error("base low bits set");
   fixed_fields_a: assert property (rd && dw == 6'h0F |=> cfgRsp.rdata[31:8] ==
      {pchr_pkg::MAX_LAT_VALUE, pchr_pkg::MIN_GNT_VALUE, pchr_pkg::INT_PIN_VALUE}) else $error("fixed fields");
   int_line_a: assert property (cfgReq.valid && cfgReq.write && dw == 6'h0F && cfgReq.byteEn[0] |=>
      interruptLine == $past(cfgReq.wdata[7:0])) else $error("line not stored");
   cap_ptr_a: assert property (rd && dw == 6'h0D |=> cfgRsp.rdata ==
      {24'h000000, $past(newCapEnabled) ? pchr_pkg::CAP_PTR_PM : pchr_pkg::CAP_PTR_NONE}) else $error("cap ptr");
   load_start_a: assert property (cnt == 16'h0031 |-> !eePins.cs ##1 eePins.cs)
      else $error("load start");
   loaded_hold_a: assert property (subsysLoaded |=> subsysLoaded) else $error("loaded fell");
   loaded_time_a: assert property (subsysLoaded |-> cnt >= LOAD_MIN_CYCLES + 16'h0032)
      else $error("loaded too soon");
endmodule : pchr_regs_checker
bind pchr_regs pchr_regs_checker #(.LOAD_MIN_CYCLES(LOAD_MIN_CYCLES)) u_chk (.clk(clk), .srst(srst),
   .cfgReq(cfgReq), .cfgRsp(cfgRsp), .newCapEnabled(newCapEnabled), .subsysLoaded(subsysLoaded),
   .interruptLine(interruptLine), .eePins(eePins));

// *** sim/pchr_ee_model.sv ***
`timescale 1ns/1ps
module pchr_ee_model #(
   parameter logic [15:0] CFG_WORD = 16'h8000,
   // Arbitrary identification words
   parameter logic [15:0] VEN_WORD = 16'h1A2B,
   parameter logic [15:0] SUB_WORD = 16'h3C4D
) (
   // Pins from the device
   input pchr_pkg::pchr_ee_pins_type eePins,
   // Serial data back
   output logic dataOut
);
   int bitCnt = 0;
   logic [8:0] cmd = 9'h000;
   wire logic [15:0] word = cmd[5:0] == 6'h00 ? CFG_WORD : (cmd[5:0] == 6'h01 ? VEN_WORD : SUB_WORD);
   initial dataOut = 1'b0;
   // Deselected line shows no stale level
   always @(negedge eePins.cs) begin
      dataOut = ~dataOut;
      bitCnt = 0;
   end
   // Command in on rising clock, dummy zero then data MSB first
   always @(posedge eePins.sk) begin
      if (eePins.cs) begin
         bitCnt = bitCnt + 1;
         if (bitCnt <= 9) begin
            cmd = {cmd[7:0], eePins.dout};
         end else if (bitCnt == 10) begin
            dataOut = 1'b0;
         end else if (bitCnt <= 26) begin
            dataOut = word[26 - bitCnt];
         end else begin
            dataOut = ~dataOut;
         end
      end
   end
endmodule : pchr_ee_model

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   // Arbitrary identification words
   localparam logic [15:0] VEN = 16'h1A2B;
   localparam logic [15:0] SUB = 16'h3C4D;
   logic clk = 1'b0;
   logic srst = 1'b1;
   pchr_pkg::pchr_cfg_req_type req = '0;
   pchr_pkg::pchr_cfg_rsp_type rsp;
   logic [31:0] memAddr = 32'h00000000;
   logic memHit;
   logic newCap;
   logic loaded;
   logic [7:0] intLine;
   pchr_pkg::pchr_ee_pins_type eePins;
   logic eeData;
   int errCount = 0;
   int checks = 0;
   always #2 clk = ~clk;
   pchr_regs #(.LOAD_MIN_CYCLES(16'h0014)) uut (.clk(clk), .srst(srst), .cfgReq(req), .cfgRsp(rsp),
      .memAddr(memAddr), .memHit(memHit), .newCapEnabled(newCap), .subsysLoaded(loaded),
      .interruptLine(intLine), .eePins(eePins), .eeDataIn(eeData));
   pchr_ee_model #(.VEN_WORD(VEN), .SUB_WORD(SUB)) u_ee (.eePins(eePins), .dataOut(eeData));
   task end_of_test;
      $display("checks=%0d errors=%0d", checks, errCount);
      if (errCount == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errCount++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task acc(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd,
      input logic [31:0] exp, input logic expRt);
      @(negedge clk);
      req = '{valid: 1'b1, write: wr, addr: a, byteEn: be, wdata: wd};
      @(negedge clk);
      req.valid = 1'b0;
      cmp({31'h0, rsp.valid}, 32'h1);
      cmp(rsp.rdata, exp);
      cmp({31'h0, rsp.retry}, {31'h0, expRt});
   endtask : acc
   task hit(input logic [31:0] a, input logic exp);
      @(negedge clk);
      memAddr = a;
      #1 cmp({31'h0, memHit}, {31'h0, exp});
   endtask : hit
   task t_reset_vals;
      acc(1'b0, 8'h10, 4'hF, 32'h0, 32'h00000000, 1'b0);
      acc(1'b0, 8'h3C, 4'hF, 32'h0, 32'h28140100, 1'b0);
      acc(1'b0, 8'h34, 4'hF, 32'h0, 32'h00000000, 1'b0);
      acc(1'b0, 8'h40, 4'hF, 32'h0, 32'h00000000, 1'b0);
      hit(32'h000007FC, 1'b1);
      hit(32'h00000800, 1'b0);
   endtask : t_reset_vals
   task t_base;
      acc(1'b1, 8'h10, 4'hF, 32'hFFFFFFFF, 32'h0, 1'b0);
      acc(1'b0, 8'h10, 4'hF, 32'h0, 32'hFFFFF800, 1'b0);
      acc(1'b1, 8'h10, 4'h2, 32'h00000000, 32'h0, 1'b0);
      acc(1'b0, 8'h10, 4'hF, 32'h0, 32'hFFFF0000, 1'b0);
      hit(32'hFFFF07FC, 1'b1);
      hit(32'hFFFEFFFC, 1'b0);
   endtask : t_base
   task t_intlat;
      acc(1'b1, 8'h3C, 4'hF, 32'hFFFFFFA5, 32'h0, 1'b0);
      acc(1'b0, 8'h3C, 4'hF, 32'h0, 32'h281401A5, 1'b0);
      cmp({24'h0, intLine}, 32'hA5);
      acc(1'b1, 8'h3C, 4'hE, 32'h00000000, 32'h0, 1'b0);
      acc(1'b0, 8'h3C, 4'hF, 32'h0, 32'h281401A5, 1'b0);
   endtask : t_intlat
   task t_sid_early;
      acc(1'b1, 8'h2C, 4'hF, 32'hFFFFFFFF, 32'h0, 1'b0);
      acc(1'b0, 8'h2C, 4'hF, 32'h0, 32'h0, 1'b1);
      acc(1'b0, 8'h2C, 4'hF, 32'h0, 32'h0, 1'b1);
      cmp({31'h0, loaded}, 32'h0);
   endtask : t_sid_early
   task t_load;
      int n;
      n = 0;
      while (loaded !== 1'b1 && n < 70000) begin
         @(negedge clk);
         n++;
      end
      cmp({31'h0, loaded}, 32'h1);
      cmp({31'h0, newCap}, 32'h1);
   endtask : t_load
   task t_sid;
      acc(1'b0, 8'h2C, 4'hF, 32'h0, {SUB, VEN}, 1'b0);
      acc(1'b1, 8'h2C, 4'hF, 32'h00000000, 32'h0, 1'b0);
      acc(1'b0, 8'h2C, 4'hF, 32'h0, {SUB, VEN}, 1'b0);
      acc(1'b0, 8'h34, 4'hF, 32'h0, 32'h00000050, 1'b0);
   endtask : t_sid
   task t_reset_mid;
      @(negedge clk);
      srst = 1'b1;
      repeat (12) @(negedge clk);
      srst = 1'b0;
      cmp({31'h0, loaded}, 32'h0);
      cmp({31'h0, newCap}, 32'h0);
      cmp({24'h0, intLine}, 32'h0);
      acc(1'b0, 8'h10, 4'hF, 32'h0, 32'h00000000, 1'b0);
      acc(1'b0, 8'h3C, 4'hF, 32'h0, 32'h28140100, 1'b0);
      acc(1'b0, 8'h2C, 4'hF, 32'h0, 32'h0, 1'b1);
   endtask : t_reset_mid
   initial begin
      #320000;
      errCount++;
      end_of_test();
   end
   initial begin
      repeat (12) @(negedge clk);
      srst = 1'b0;
      t_reset_vals();
      t_base();
      t_intlat();
      t_sid_early();
      t_load();
      t_sid();
      t_reset_mid();
      end_of_test();
   end
endmodule : tb_top
